// *** src/audcfg_pkg.sv ***
// Constants for the audio function configuration register bank.
// Assumes one 20 MHz clock and byte offsets within the function's config space.
package audcfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_BASE_ADDR_SLOT_THREE = 8'h1C;
  localparam logic [7:0] OFF_BASE_ADDR_SLOT_FOUR = 8'h20;
  localparam logic [7:0] OFF_BASE_ADDR_SLOT_FIVE = 8'h24;
  localparam logic [7:0] OFF_SUBSYSTEM_IDENT = 8'h2C;
  localparam logic [7:0] OFF_EXPANSION_ROM_BASE = 8'h30;
  localparam logic [7:0] OFF_CAPABILITY_LIST_POINTER = 8'h34;
  localparam logic [7:0] OFF_LEGACY_INTERRUPT_ROUTING = 8'h3C;
  localparam logic [7:0] OFF_SUBSYSTEM_IDENT_WRITER = 8'h4C;
  localparam logic [7:0] OFF_POWER_MGMT_CAP_HEADER = 8'h50;
  localparam logic [7:0] OFF_POWER_MGMT_CTRL_STATUS = 8'h54;
  localparam logic [7:0] OFF_EXPRESS_CAP_HEADER = 8'h58;
  localparam logic [7:0] OFF_ENDPOINT_CAPABILITY = 8'h5C;
  localparam logic [7:0] OFF_ENDPOINT_CTRL_STATUS = 8'h60;
  localparam logic [7:0] OFF_LINK_CAPABILITY_INFO = 8'h64;
  localparam logic [7:0] OFF_LINK_CTRL_STATUS = 8'h68;
  localparam logic [7:0] OFF_ENDPOINT_CAPABILITY_TWO = 8'h7C;

  // ----------------------------------------------------------------
  // Fixed values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CAP_LIST_HEAD = 8'h50;
  localparam logic [7:0] LEGACY_IRQ_PIN_CODE = 8'h02;
  localparam logic [7:0] IRQ_ROUTING_RESET = 8'hFF;
  localparam logic [31:0] PM_CAP_HEADER = 32'h0603_0001;
  localparam logic [7:0] EXP_CAP_ID = 8'h10;
  localparam logic [3:0] EXP_CAP_VERSION = 4'h2;
  localparam logic [3:0] EXP_PORT_TYPE = 4'h9;
  localparam logic [4:0] MSG_VECTOR_INDEX = 5'h00;
  localparam logic [31:0] ENDPOINT_CAP_BASE = 32'h0000_8FA0;
  localparam int FLR_CAP_BIT = 28;
  localparam logic [31:0] DEVCTL_RESET = 32'h0000_0810;
  localparam logic [31:0] DEVCTL_RW_MASK = 32'h0000_091F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DC_WIDE_TAG = 8;
  localparam int DC_SKIP_COHERENCY = 11;
  localparam int DC_LOOSE_ORDERING = 4;
  localparam int DC_ERR_LO = 16;
  localparam int LS_LINK_UP = 29;
  localparam int LS_TRAINING = 27;
  localparam int ERR_UR = 3;
  localparam int ERR_FATAL = 2;
  localparam int ERR_NONFATAL = 1;
  localparam int ERR_CORR = 0;

  // ----------------------------------------------------------------
  // Power states and request limits
  // ----------------------------------------------------------------
  localparam logic [1:0] PSTATE_FULL_ON = 2'h0;
  localparam logic [1:0] PSTATE_HOT_LOW = 2'h3;
  localparam logic [11:0] READ_REQ_MAX_BYTES = 12'h080;
  localparam logic [11:0] COMPLETION_BOUNDARY_BYTES = 12'h040;

  // Error message classes.
  typedef enum logic [1:0] {
    MSG_CORR,
    MSG_NONFATAL,
    MSG_FATAL
  } audcfg_msg_e;

endpackage

// *** src/audcfg_err_if.sv ***
// Signals between the register bank and its error flag unit.
// Assumes both ends share the bank's clock.
`timescale 1ns/1ns
`default_nettype none
interface audcfg_err_if;
  import audcfg_pkg::*;
  logic [3:0] detect;
  logic [3:0] clear;
  logic [3:0] report_on;
  logic [3:0] flags;
  logic msg_valid;
  logic msg_ready;
  audcfg_msg_e msg_kind;
  modport bank (output detect, clear, report_on, msg_ready, input flags, msg_valid, msg_kind);
  modport unit (input detect, clear, report_on, msg_ready, output flags, msg_valid, msg_kind);
endinterface
`default_nettype wire

// *** src/audcfg_err_unit.sv ***
// Sticky error flags with write-one-to-clear and error message queueing.
// Assumes detect pulses and clears come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module audcfg_err_unit
  import audcfg_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Link to the register bank.
  audcfg_err_if.unit err
);

  logic [3:0] flags_q, flags_d;
  logic [2:0] pend_q, pend_d;
  logic [2:0] pend_set, pend_sent;

  // Next flags: a detect in the clearing cycle wins.
  always_comb begin
    flags_d = (flags_q & ~err.clear) | err.detect; // see [RULE9]
    pend_set[2] = err.detect[ERR_FATAL] & err.report_on[ERR_FATAL]; // see [RULE10]
    pend_set[1] = (err.detect[ERR_NONFATAL] & err.report_on[ERR_NONFATAL])
                | (err.detect[ERR_UR] & err.report_on[ERR_UR]); // see [RULE10]
    pend_set[0] = err.detect[ERR_CORR] & err.report_on[ERR_CORR]; // see [RULE10]
    pend_sent = 3'h0;
    if (err.msg_ready) begin
      if (pend_q[2]) begin
        pend_sent = 3'h4;
      end else if (pend_q[1]) begin
        pend_sent = 3'h2;
      end else if (pend_q[0]) begin
        pend_sent = 3'h1;
      end
    end
    pend_d = (pend_q & ~pend_sent) | pend_set;
  end

  // Register flags and pending messages.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flags_q <= 4'h0;
      pend_q <= 3'h0;
    end else begin
      flags_q <= flags_d;
      pend_q <= pend_d;
    end
  end

  // Most severe pending class is offered first.
  assign err.flags = flags_q;
  assign err.msg_valid = |pend_q;
  assign err.msg_kind = pend_q[2] ? MSG_FATAL : (pend_q[1] ? MSG_NONFATAL : MSG_CORR);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_fatal_seen;
    err.detect[ERR_FATAL] && err.report_on[ERR_FATAL];
  endsequence

  chk_flag_sticky: assert property (@(posedge clk_in) disable iff (!nrst_in) // see [RULE9]
    flags_q[0] && !err.clear[0] |=> flags_q[0])
    else $error("Error flag dropped without a clear.");

  chk_fatal_msg: assert property (@(posedge clk_in) disable iff (!nrst_in) // see [RULE10]
    s_fatal_seen |=> err.msg_valid && err.msg_kind == MSG_FATAL)
    else $error("Fatal error produced no fatal message.");

  chk_msg_gated: assert property (@(posedge clk_in) disable iff (!nrst_in) // see [RULE10]
    !err.msg_valid && err.report_on == 4'h0 |=> !err.msg_valid)
    else $error("Error message sent with reporting off.");

endmodule
`default_nettype wire

// *** src/audcfg_bank.sv ***
// Configuration register bank of an audio controller PCIe endpoint function.
// Assumes config reads and writes arrive as one-cycle strobes on clk_in.
//
// Functional notes
// [RULE1] Subsystem ident reads only; values load through the writable mirror register.
// [RULE2] Capability list head reads fixed 50h, pointing at power management.
// [RULE3] Interrupt register: fixed pin code 02h high, routing byte resets FFh.
// [RULE4] PM header: id 01h, version 011b, no wake, no aux, D1/D2.
// [RULE5] Power state: 00b full on, 11b hot low power, middle codes reserved.
// [RULE6] Software reinitialises after hot low power; keeps-state bit reads zero.
// [RULE7] Express header: id 10h, version 2h, type 9h, no slot, vector 0.
// [RULE8] Device cap: 128-byte payload, 8-bit tags, role errors, latencies 111b/110b.
// [RULE9] Four error flags set on detection and clear only on write-one.
// [RULE10] Enabled error classes send fatal, nonfatal or correctable messages.
// [RULE11] Wide tag enable selects 8-bit tags, else 5-bit tags.
// [RULE12] No-snoop and relaxed-ordering attributes allowed only when enabled; reset one.
// [RULE13] Read requests never exceed 128 bytes; size field reads zero.
// [RULE14] Link-up bit follows data link active state.
// [RULE15] Training bit is set in configuration, recovery or pending retrain.
// [RULE16] Completion boundary field reads zero; boundary is 64 bytes.
// [RULE17] Reserved registers and fields read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
module audcfg_bank
  import audcfg_pkg::*;
#(
  parameter logic [7:0] EXP_NEXT_PTR = 8'h00,
  parameter logic FLR_CAPABLE = 1'b0
)
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Configuration access port.
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  // Error events and messages.
  input wire logic unsupported_req_in,
  input wire logic fatal_err_in,
  input wire logic nonfatal_err_in,
  input wire logic corr_err_in,
  output logic err_msg_valid_out,
  output logic [1:0] err_msg_kind_out,
  input wire logic err_msg_ready_in,
  // Link state from the link layers.
  input wire logic link_layer_up_in,
  input wire logic phy_cfg_or_recovery_in,
  input wire logic retrain_request_in,
  // Request attribute controls and power state.
  output logic wide_tag_on_out,
  output logic skip_coherency_attr_on_out,
  output logic loose_ordering_attr_on_out,
  output logic [11:0] read_req_max_bytes_out,
  output logic [11:0] completion_boundary_bytes_out,
  output logic [1:0] power_state_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] subsys_q, subsys_d;
  logic [7:0] irq_routing_byte_q, irq_routing_byte_d;
  logic [1:0] pstate_q, pstate_d;
  logic [31:0] devctl_q, devctl_d;
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] wmask;
  logic [31:0] wmerge_sub;
  logic [31:0] devstat;
  logic [31:0] linkstat;
  logic [31:0] exp_hdr;
  logic [31:0] dev_cap;
  audcfg_err_if err ();

  // Byte enables widened to a bit mask.
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // Error flag unit
  // ----------------------------------------------------------------
  audcfg_err_unit u_err (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .err(err.unit)
  );

  // Events, enables and write-one clears toward the flag unit.
  always_comb begin
    err.detect = {unsupported_req_in, fatal_err_in, nonfatal_err_in, corr_err_in};
    err.report_on = devctl_q[3:0]; // see [RULE10]
    err.clear = 4'h0;
    if (cfg_wr_in && cfg_addr_in == OFF_ENDPOINT_CTRL_STATUS && cfg_be_in[2]) begin
      err.clear = cfg_wdata_in[DC_ERR_LO +: 4]; // see [RULE9]
    end
    err.msg_ready = err_msg_ready_in;
  end

  // ----------------------------------------------------------------
  // Fixed and status read values
  // ----------------------------------------------------------------
  assign exp_hdr = {2'h0, MSG_VECTOR_INDEX, 1'b0, EXP_PORT_TYPE, EXP_CAP_VERSION,
                    EXP_NEXT_PTR, EXP_CAP_ID}; // see [RULE7]
  assign dev_cap = ENDPOINT_CAP_BASE | ({31'h0, FLR_CAPABLE} << FLR_CAP_BIT); // see [RULE8]
  // Error flags sit above the control bits; size fields read zero.
  assign devstat = {12'h000, err.flags, 4'h0, devctl_q[11:0]}; // see [RULE13]
  // Link status; the completion boundary bit stays zero.
  always_comb begin
    linkstat = 32'h0; // see [RULE16]
    linkstat[LS_LINK_UP] = link_layer_up_in; // see [RULE14]
    linkstat[LS_TRAINING] = phy_cfg_or_recovery_in | retrain_request_in; // see [RULE15]
  end

  // ----------------------------------------------------------------
  // Write side
  // ----------------------------------------------------------------
  assign wmask = be_mask(cfg_be_in);
  assign wmerge_sub = (subsys_q & ~wmask) | (cfg_wdata_in & wmask);

  // Next values of the writable registers.
  always_comb begin
    subsys_d = subsys_q;
    irq_routing_byte_d = irq_routing_byte_q;
    pstate_d = pstate_q;
    devctl_d = devctl_q;
    if (cfg_wr_in) begin
      case (cfg_addr_in)
        OFF_SUBSYSTEM_IDENT_WRITER: begin
          subsys_d = wmerge_sub; // see [RULE1]
        end
        OFF_LEGACY_INTERRUPT_ROUTING: begin
          if (cfg_be_in[0]) begin
            irq_routing_byte_d = cfg_wdata_in[7:0]; // see [RULE3]
          end
        end
        OFF_POWER_MGMT_CTRL_STATUS: begin
          // Reserved state codes are refused and the state holds.
          if (cfg_be_in[0] && (cfg_wdata_in[1:0] == PSTATE_FULL_ON ||
                               cfg_wdata_in[1:0] == PSTATE_HOT_LOW)) begin
            pstate_d = cfg_wdata_in[1:0]; // see [RULE5]
          end
        end
        OFF_ENDPOINT_CTRL_STATUS: begin
          devctl_d = ((devctl_q & ~wmask) | (cfg_wdata_in & wmask)) & DEVCTL_RW_MASK; // see [RULE12]
        end
        default: begin
          subsys_d = subsys_q; // see [RULE17]
        end
      endcase
    end
  end

  // Register the writable state.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      subsys_q <= 32'h0;
      irq_routing_byte_q <= IRQ_ROUTING_RESET;
      pstate_q <= PSTATE_FULL_ON;
      devctl_q <= DEVCTL_RESET;
    end else begin
      subsys_q <= subsys_d;
      irq_routing_byte_q <= irq_routing_byte_d;
      pstate_q <= pstate_d;
      devctl_q <= devctl_d;
    end
  end

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  // Read data mux; unmapped and reserved offsets read zero.
  always_comb begin
    rvalid_d = cfg_rd_in;
    rdata_d = rdata_q;
    if (cfg_rd_in) begin
      case (cfg_addr_in)
        OFF_SUBSYSTEM_IDENT: rdata_d = subsys_q; // see [RULE1]
        OFF_SUBSYSTEM_IDENT_WRITER: rdata_d = subsys_q;
        OFF_CAPABILITY_LIST_POINTER: rdata_d = {24'h0, CAP_LIST_HEAD}; // see [RULE2]
        OFF_LEGACY_INTERRUPT_ROUTING: rdata_d = {16'h0, LEGACY_IRQ_PIN_CODE, irq_routing_byte_q}; // see [RULE3]
        OFF_POWER_MGMT_CAP_HEADER: rdata_d = PM_CAP_HEADER; // see [RULE4]
        OFF_POWER_MGMT_CTRL_STATUS: rdata_d = {30'h0, pstate_q}; // see [RULE6]
        OFF_EXPRESS_CAP_HEADER: rdata_d = exp_hdr;
        OFF_ENDPOINT_CAPABILITY: rdata_d = dev_cap;
        OFF_ENDPOINT_CTRL_STATUS: rdata_d = devstat;
        OFF_LINK_CTRL_STATUS: rdata_d = linkstat;
        default: rdata_d = 32'h0; // see [RULE17]
      endcase
    end
  end

  // Register the read answer.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= 32'h0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_rdata_out = rdata_q;
  assign cfg_rvalid_out = rvalid_q;
  assign err_msg_valid_out = err.msg_valid;
  assign err_msg_kind_out = err.msg_kind;
  assign wide_tag_on_out = devctl_q[DC_WIDE_TAG]; // see [RULE11]
  assign skip_coherency_attr_on_out = devctl_q[DC_SKIP_COHERENCY]; // see [RULE12]
  assign loose_ordering_attr_on_out = devctl_q[DC_LOOSE_ORDERING]; // see [RULE12]
  assign read_req_max_bytes_out = READ_REQ_MAX_BYTES; // see [RULE13]
  assign completion_boundary_bytes_out = COMPLETION_BOUNDARY_BYTES; // see [RULE16]
  assign power_state_out = pstate_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_mirror_write;
    cfg_wr_in && cfg_addr_in == OFF_SUBSYSTEM_IDENT_WRITER && cfg_be_in == 4'hF;
  endsequence

  sequence s_ident_read;
    cfg_rd_in && !cfg_wr_in && cfg_addr_in == OFF_SUBSYSTEM_IDENT;
  endsequence

  chk_subsys_mirror: assert property ( // see [RULE1]
    s_mirror_write ##1 s_ident_read |=> cfg_rdata_out == $past(cfg_wdata_in, 2))
    else $error("Subsystem ident does not follow the mirror write.");

  chk_subsys_readonly: assert property ( // see [RULE1]
    cfg_wr_in && cfg_addr_in == OFF_SUBSYSTEM_IDENT |=> $stable(subsys_q))
    else $error("Subsystem ident changed by a direct write.");

  chk_cap_head: assert property ( // see [RULE2]
    cfg_rd_in && cfg_addr_in == OFF_CAPABILITY_LIST_POINTER |=> cfg_rvalid_out && cfg_rdata_out == 32'h0000_0050)
    else $error("Capability list head is not 50h.");

  chk_irq_pin: assert property ( // see [RULE3]
    cfg_rd_in && cfg_addr_in == OFF_LEGACY_INTERRUPT_ROUTING |=> cfg_rdata_out[31:8] == 24'h000002)
    else $error("Interrupt pin code is wrong.");

  chk_pm_header: assert property ( // see [RULE4]
    cfg_rd_in && cfg_addr_in == OFF_POWER_MGMT_CAP_HEADER |=> cfg_rdata_out == 32'h0603_0001)
    else $error("Power management header is wrong.");

  chk_pstate_legal: assert property ( // see [RULE5]
    cfg_wr_in && cfg_addr_in == OFF_POWER_MGMT_CTRL_STATUS && cfg_wdata_in[1] != cfg_wdata_in[0]
    |=> $stable(power_state_out))
    else $error("Reserved power state was accepted.");

  chk_exp_header: assert property ( // see [RULE7]
    cfg_rd_in && cfg_addr_in == OFF_EXPRESS_CAP_HEADER |=> cfg_rdata_out[31:16] == 16'h0092
    && cfg_rdata_out[7:0] == 8'h10)
    else $error("Express header is wrong.");

  chk_dev_cap: assert property ( // see [RULE8]
    cfg_rd_in && cfg_addr_in == OFF_ENDPOINT_CAPABILITY |=> cfg_rdata_out[15:0] == 16'h8FA0)
    else $error("Device capability is wrong.");

  chk_err_w1c: assert property ( // see [RULE9]
    fatal_err_in ##1 (cfg_wr_in && cfg_addr_in == OFF_ENDPOINT_CTRL_STATUS && cfg_be_in[2]
    && cfg_wdata_in[18] && !fatal_err_in) |=> !err.flags[ERR_FATAL])
    else $error("Fatal flag not cleared by a one write.");

  chk_tag_width: assert property ( // see [RULE11]
    cfg_wr_in && cfg_addr_in == OFF_ENDPOINT_CTRL_STATUS && cfg_be_in[1]
    |=> wide_tag_on_out == $past(cfg_wdata_in[8]))
    else $error("Wide tag enable did not follow the write.");

  chk_link_up: assert property ( // see [RULE14]
    cfg_rd_in && cfg_addr_in == OFF_LINK_CTRL_STATUS |=> cfg_rdata_out[29] == $past(link_layer_up_in)
    && !cfg_rdata_out[3])
    else $error("Link-up bit does not follow the link layer.");

  chk_training: assert property ( // see [RULE15]
    cfg_rd_in && cfg_addr_in == OFF_LINK_CTRL_STATUS |=> cfg_rdata_out[27] ==
    ($past(phy_cfg_or_recovery_in) || $past(retrain_request_in)))
    else $error("Training bit is wrong.");

  chk_reserved_zero: assert property ( // see [RULE17]
    cfg_rd_in && (cfg_addr_in == OFF_EXPANSION_ROM_BASE || cfg_addr_in == OFF_BASE_ADDR_SLOT_THREE)
    |=> cfg_rdata_out == 32'h0)
    else $error("Reserved register reads non-zero.");

endmodule
`default_nettype wire

// *** tb/audcfg_bank_bench.sv ***
// Self-checking bench for the audio function configuration register bank.
// Assumes reads answer one cycle after the strobe and writes show on the next read.
`timescale 1ns/1ns
`default_nettype none
module audcfg_bank_bench
  import audcfg_pkg::*;
();
  // --------------------------------------------------------------
  // Stimulus signals and the unit under test
  // --------------------------------------------------------------
  localparam logic [7:0] NP = 8'hA0;
  localparam logic [7:0] ADDRS [17] = '{8'h1C, 8'h20, 8'h24, 8'h2C, 8'h30, 8'h34, 8'h3C, 8'h4C, 8'h50,
                                        8'h54, 8'h58, 8'h5C, 8'h60, 8'h64, 8'h68, 8'h7C, 8'h40};
  logic clk_in, nrst_in, cfg_wr_in, cfg_rd_in, cfg_rvalid_out, err_msg_ready_in, err_msg_valid_out;
  logic link_up, phy_cfg, retrain, wide_tag, skip_coh, loose_ord;
  logic [7:0] cfg_addr_in;
  logic [3:0] cfg_be_in, ev;
  logic [31:0] cfg_wdata_in, cfg_rdata_out, rd_val, d, d2;
  logic [1:0] err_msg_kind_out, power_state_out, pstate;
  logic [11:0] rq_max, cpl_bnd;
  int fail_count, compares, seed;

  // The next-pointer and function-reset values are arbitrary picks for this bench.
  audcfg_bank #(.EXP_NEXT_PTR(NP), .FLR_CAPABLE(1'b1)) uut (
    .clk_in(clk_in), .nrst_in(nrst_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
    .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
    .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
    .unsupported_req_in(ev[3]), .fatal_err_in(ev[2]), .nonfatal_err_in(ev[1]), .corr_err_in(ev[0]),
    .err_msg_valid_out(err_msg_valid_out), .err_msg_kind_out(err_msg_kind_out),
    .err_msg_ready_in(err_msg_ready_in), .link_layer_up_in(link_up), .phy_cfg_or_recovery_in(phy_cfg),
    .retrain_request_in(retrain), .wide_tag_on_out(wide_tag), .skip_coherency_attr_on_out(skip_coh),
    .loose_ordering_attr_on_out(loose_ord), .read_req_max_bytes_out(rq_max),
    .completion_boundary_bytes_out(cpl_bnd), .power_state_out(power_state_out)
  );

  // --------------------------------------------------------------
  // Expectations, bus tasks and reporting
  // --------------------------------------------------------------
  // Reset contents of each offset; unmapped and reserved places read zero.
  function automatic logic [31:0] exp_val(input logic [7:0] a);
    case (a)
      8'h34: exp_val = 32'h0000_0050;
      8'h3C: exp_val = 32'h0000_02FF;
      8'h50: exp_val = 32'h0603_0001;
      8'h58: exp_val = {8'h00, 8'h92, NP, 8'h10};
      8'h5C: exp_val = 32'h1000_8FA0;
      8'h60: exp_val = 32'h0000_0810;
      default: exp_val = 32'h0000_0000;
    endcase
  endfunction

  // Byte-lane merge of a partial write.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
    for (int i = 0; i < 4; i++) merge[8*i +: 8] = be[i] ? n[8*i +: 8] : o[8*i +: 8];
  endfunction

  // Message class for an error index: unsupported requests travel as non-fatal.
  function automatic logic [31:0] msg_kind(input int i);
    msg_kind = (i == 2) ? 32'h2 : ((i == 0) ? 32'h0 : 32'h1);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("mismatches=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One write strobe; the strobe drops at the following edge.
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    @(posedge clk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_be_in <= be;
    cfg_wdata_in <= v;
    @(posedge clk_in);
    cfg_wr_in <= 1'b0;
  endtask

  // One read strobe; waits a bounded time for the answer pulse.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    @(posedge clk_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge clk_in);
    cfg_rd_in <= 1'b0;
    n = 0;
    #1;
    while (cfg_rvalid_out !== 1'b1 && n < 4) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n == 4) begin
      fail_count++;
      stop_test();
    end
    v = cfg_rdata_out;
  endtask

  // Free-running 20 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // Watchdog that ends a hung run as a failure.
  initial begin
    repeat (100000) @(posedge clk_in);
    fail_count++;
    stop_test();
  end

  // Main sequence: reset, register table, writable fields, errors and link state.
  initial begin
    seed = 32'he775;
    fail_count = 0;
    compares = 0;
    {nrst_in, cfg_wr_in, cfg_rd_in, err_msg_ready_in, link_up, phy_cfg, retrain} = 7'h00;
    {cfg_addr_in, cfg_be_in, ev, cfg_wdata_in} = 48'h0;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk({29'h0, wide_tag, skip_coh, loose_ord}, 32'h3);
    chk({rq_max, 8'h00, cpl_bnd}, {12'h080, 8'h00, 12'h040});
    for (int k = 0; k < 17; k++) begin
      rd(ADDRS[k], rd_val);
      chk(rd_val, exp_val(ADDRS[k]));
      if (!(ADDRS[k] inside {8'h3C, 8'h4C, 8'h54, 8'h60})) begin
        wr(ADDRS[k], 4'hF, $random(seed));
        rd(ADDRS[k], rd_val);
        chk(rd_val, exp_val(ADDRS[k]));
      end
    end
    d = $random(seed);
    d2 = $random(seed);
    wr(8'h4C, 4'hF, d);
    rd(8'h2C, rd_val);
    chk(rd_val, d);
    wr(8'h4C, 4'h5, d2);
    rd(8'h2C, rd_val);
    chk(rd_val, merge(d, d2, 4'h5));
    wr(8'h3C, 4'hF, d);
    rd(8'h3C, rd_val);
    chk(rd_val, {16'h0, 8'h02, d[7:0]});
    // Every power code in turn; the reserved middle codes leave the state alone.
    pstate = 2'h0;
    for (int k = 0; k < 6; k++) begin
      d = $random(seed);
      d[1:0] = 2'(k) ^ 2'h3;
      wr(8'h54, 4'hF, d);
      if (d[1:0] == 2'h0 || d[1:0] == 2'h3) pstate = d[1:0];
      rd(8'h54, rd_val);
      // Bit 3 must read zero, so software reinitialises after leaving hot low power.
      chk(rd_val, {30'h0, pstate});
      chk({30'h0, power_state_out}, {30'h0, pstate});
    end
    for (int k = 0; k < 4; k++) begin
      d = $random(seed) & 32'hFFF0_FFFF;
      wr(8'h60, 4'hF, d);
      rd(8'h60, rd_val);
      chk(rd_val, d & 32'h0000_091F);
      chk({29'h0, wide_tag, skip_coh, loose_ord}, {29'h0, d[8], d[11], d[4]});
    end
    // Each error class with reporting off, then on; flags clear only on a one.
    for (int en = 0; en < 2; en++) begin
      for (int i = 0; i < 4; i++) begin
        wr(8'h60, 4'hF, (en != 0) ? 32'h0000_000F : 32'h0);
        @(posedge clk_in);
        ev <= 4'h1 << i;
        @(posedge clk_in);
        ev <= 4'h0;
        #1;
        chk({31'h0, err_msg_valid_out}, 32'(en));
        if (en != 0) chk({30'h0, err_msg_kind_out}, msg_kind(i));
        @(posedge clk_in);
        err_msg_ready_in <= 1'b1;
        @(posedge clk_in);
        err_msg_ready_in <= 1'b0;
        #1;
        chk({31'h0, err_msg_valid_out}, 32'h0);
        wr(8'h60, 4'hF, ~(32'h1 << (16 + i)) & 32'h000F_0000);
        rd(8'h60, rd_val);
        chk({28'h0, rd_val[19:16]}, 32'h1 << i);
        wr(8'h60, 4'h4, 32'h1 << (16 + i));
        rd(8'h60, rd_val);
        chk({28'h0, rd_val[19:16]}, 32'h0);
      end
    end
    // Back to back: a mirror write read on the very next edge, answer one cycle later.
    @(posedge clk_in);
    {cfg_wr_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} <= {1'b1, 8'h4C, 4'hF, d2};
    @(posedge clk_in);
    {cfg_wr_in, cfg_rd_in, cfg_addr_in} <= {1'b0, 1'b1, 8'h2C};
    @(posedge clk_in);
    cfg_rd_in <= 1'b0;
    ev <= 4'h4;
    #1;
    chk({31'h0, cfg_rvalid_out}, 32'h1);
    chk(cfg_rdata_out, d2);
    // A fatal flag cleared right after its event, then set again while the clear repeats.
    @(posedge clk_in);
    ev <= 4'h0;
    {cfg_wr_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} <= {1'b1, 8'h60, 4'h4, 32'h0004_0000};
    @(posedge clk_in);
    ev <= 4'h4;
    @(posedge clk_in);
    ev <= 4'h0;
    {cfg_wr_in, cfg_rd_in} <= 2'b01;
    @(posedge clk_in);
    cfg_rd_in <= 1'b0;
    #1;
    chk({31'h0, cfg_rdata_out[18]}, 32'h1);
    for (int j = 0; j < 8; j++) begin
      @(posedge clk_in);
      {retrain, phy_cfg, link_up} <= 3'(j);
      rd(8'h68, rd_val);
      chk(rd_val, {2'h0, j[0], 1'b0, j[1] | j[2], 27'h0});
    end
    stop_test();
  end
endmodule
`default_nettype wire
